// file: dv/rlfm_far_end.sv
// Remote transmitter model feeding all receive channels.
// Assumes the monitor clock; quiet freezes the line, as a lost stream.
`timescale 1ns/1ns
module rlfm_far_end
	import rlfm_pkg::*;
#(
	parameter int N = NUM_CHAN
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             quiet,
	input  wire logic [9:0]       amp,
	input  wire logic [15:0]      vco,
	output rlfm_chan_in_s [N-1:0] chan_in
);
	logic [2:0] cnt_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			cnt_reg <= 3'h0;
		else if (!quiet)
			cnt_reg <= cnt_reg + 3'h1;
	end
	always_comb begin
		for (int i = 0; i < N; i++) begin
			chan_in[i].line_bit     = cnt_reg[2];
			chan_in[i].loop_bit     = ~cnt_reg[2];
			chan_in[i].amplitude_mv = amp;
			chan_in[i].vco_count    = vco;
		end
	end
endmodule : rlfm_far_end

// file: dv/rlfm_top_assertions.sv
// Port checker for the link-fault monitor top.
// Assumes it is bound into rlfm_top; one clock domain.
`timescale 1ns/1ns
module rlfm_top_assertions
	import rlfm_pkg::*;
#(
	parameter int N      = NUM_CHAN,
	parameter int PERIOD = RANGE_PERIOD
) (
	input wire logic                   clock,
	input wire logic                   resetn,
	input wire logic                   tx_half_rate_select,
	input wire rlfm_level_e            amplitude_threshold_select,
	input wire logic [N-1:0]           loopback_enable,
	input wire logic                   rx_enable_latch_open,
	input wire logic [CTRL_BUS_W-1:0]  channel_control_bus,
	input wire rlfm_chan_in_s [N-1:0]  chan_in,
	input wire rlfm_rate_s             rate_setup,
	input wire logic                   char_clock_tick,
	input wire logic [N-1:0]           tx_serial_out,
	input wire rlfm_chan_ctl_s [N-1:0] chan_ctl,
	input wire logic [N-1:0]           rx_channel_enabled,
	input wire logic [N-1:0]           link_fault_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Quiet time of channel 0 line; saturates so it never wraps
	logic       prev_reg;
	logic [6:0] quiet_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prev_reg  <= 1'b0;
			quiet_reg <= 7'h00;
		end else begin
			prev_reg <= chan_in[0].line_bit;
			if (chan_in[0].line_bit != prev_reg)
				quiet_reg <= 7'h00;
			else if (quiet_reg != 7'h7F)
				quiet_reg <= quiet_reg + 7'h01;
		end
	end
	sequence loop_held;
		loopback_enable[0] [*6];
	endsequence
	sequence latch_steady;
		(rx_enable_latch_open && $stable(channel_control_bus)) [*7];
	endsequence
	tx_quiet_a: assert property (
		(|loopback_enable) [*6] |-> &tx_serial_out)
		else $error("tx outputs not high in loopback");
	loop_route_a: assert property (
		loop_held |-> {chan_ctl[0].cdr_input_is_loop,
		chan_ctl[0].line_rx_select, chan_ctl[0].amp_monitor_on} == 3'h4)
		else $error("loopback steering wrong");
	mult_rate_a: assert property (
		$stable(tx_half_rate_select) [*6]
		|-> rate_setup.multiplier == (tx_half_rate_select ? 5'h14 : 5'h0A))
		else $error("multiplier wrong");
	tick_gap_a: assert property (
		char_clock_tick |=> !char_clock_tick [*8])
		else $error("char tick too soon");
	off_fault_a: assert property (
		(~rx_channel_enabled & ~$past(rx_channel_enabled)
		& link_fault_n) == '0)
		else $error("disabled channel shows good link");
	off_power_a: assert property (
		!rx_channel_enabled[0] |-> !chan_ctl[0].powered)
		else $error("disabled channel powered");
	latch_pass_a: assert property (
		latch_steady |-> rx_channel_enabled ==
		{channel_control_bus[6], channel_control_bus[4],
		channel_control_bus[2], channel_control_bus[0]})
		else $error("open latch not passing bus");
	latch_hold_a: assert property (
		!rx_enable_latch_open [*7] |=> $stable(rx_channel_enabled))
		else $error("closed latch changed");
	amp_trip_a: assert property (
		(amplitude_threshold_select == RLFM_LVL_HIGH
		&& chan_in[0].amplitude_mv < 10'h1A4 && !loopback_enable[0]) [*6]
		|-> !link_fault_n[0])
		else $error("low amplitude not flagged");
	quiet_fault_a: assert property (
		quiet_reg > 7'h46 && !loopback_enable[0] |-> !link_fault_n[0])
		else $error("missing transitions not flagged");
	force_fault_a: assert property (
		chan_ctl[0].force_nominal |=> !link_fault_n[0])
		else $error("link shown good while forcing nominal");
endmodule : rlfm_top_assertions

// file: dv/rlfm_top_tb.sv
// Self-checking bench for the link-fault monitor top.
// Assumes the far-end model and the checker are compiled first.
`timescale 1ns/1ns
module rlfm_top_tb;
	import rlfm_pkg::*;
	localparam int N      = NUM_CHAN;
	localparam int PERIOD = 200;
	logic                  clock, resetn, half, latch_open, quiet, tick;
	rlfm_level_e           spd, amp_sel;
	logic [N-1:0]          loop_en, tx_data, tx_out, rx_en, lfn;
	logic [7:0]            bus;
	logic [9:0]            amp;
	logic [15:0]           vco;
	rlfm_chan_in_s [N-1:0] chan_in;
	rlfm_chan_ctl_s [N-1:0] ctl;
	rlfm_rate_s            rate;
	int                    n_errors, n_checks, cycles, gap;
	logic [11:0] bmin [3] = '{12'h00C3, 12'h0190, 12'h0320};
	logic [11:0] bmax [3] = '{12'h0190, 12'h0320, 12'h05DC};
	rlfm_far_end #(.N(N)) i_rlfm_far_end (.clock(clock), .resetn(resetn),
		.quiet(quiet), .amp(amp), .vco(vco), .chan_in(chan_in));
	rlfm_top #(.N(N), .PERIOD(PERIOD)) i_rlfm_top (.clock(clock),
		.resetn(resetn), .tx_half_rate_select(half),
		.speed_range_select(spd), .amplitude_threshold_select(amp_sel),
		.loopback_enable(loop_en), .rx_enable_latch_open(latch_open),
		.channel_control_bus(bus), .tx_serial_data(tx_data),
		.chan_in(chan_in), .rate_setup(rate), .char_clock_tick(tick),
		.tx_serial_out(tx_out), .chan_ctl(ctl),
		.rx_channel_enabled(rx_en), .link_fault_n(lfn));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	// Bounded wait on channel 0 status, then compare
	task automatic wait_lf(input logic exp, input int lim);
		int k;
		k = 0;
		while (lfn[0] !== exp && k < lim) begin
			@(negedge clock);
			k++;
		end
		chk(lfn[0], exp);
	endtask : wait_lf
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Run needs about 1100 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 10000) begin
			n_errors++;
			end_sim();
		end
	end
	always @(negedge clock) tx_data <= ~tx_data;
	initial begin
		{half, latch_open, quiet, loop_en, tx_data, bus} = '0;
		spd = RLFM_LVL_HIGH;
		amp_sel = RLFM_LVL_MID;
		amp = 10'h12C;
		vco = 16'(PERIOD);
		n_errors = 0;
		n_checks = 0;
		cycles = 0;
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		chk(rx_en, 4'h0);
		chk(lfn, 4'h0);
		latch_open = 1'b1;
		bus = 8'hAA;
		cyc(8);
		chk(rx_en, 4'h0);
		bus = 8'h55;
		cyc(8);
		chk(rx_en, 4'hF);
		chk(ctl[0].powered, 1'b1);
		latch_open = 1'b0;
		cyc(8);
		bus = 8'h00;
		cyc(8);
		chk(rx_en, 4'hF);
		for (int s = 0; s < 3; s++) begin
			for (int h = 0; h < 2; h++) begin
				spd = rlfm_level_e'(s);
				half = h[0];
				cyc(8);
				chk(rate.multiplier, h ? 5'h14 : 5'h0A);
				chk(rate.baud_min, bmin[s]);
				chk(rate.baud_max, bmax[s]);
				chk(rate.reserved_mode, h == 1 && s == 0);
			end
		end
		spd = RLFM_LVL_HIGH;
		half = 1'b0;
		cyc(8);
		@(posedge tick);
		gap = cycles;
		@(posedge tick);
		chk(cycles - gap, 10);
		cyc(1);
		wait_lf(1'b1, 3 * PERIOD);
		amp_sel = RLFM_LVL_HIGH;
		wait_lf(1'b0, 12);
		cyc(8);
		amp_sel = RLFM_LVL_MID;
		wait_lf(1'b1, 3 * PERIOD);
		quiet = 1'b1;
		cyc(50);
		chk(lfn[0], 1'b1);
		wait_lf(1'b0, 30);
		cyc(10);
		quiet = 1'b0;
		cyc(15);
		chk(lfn[0], 1'b0);
		wait_lf(1'b1, 60);
		vco = 16'(PERIOD + 20);
		cyc(2 * PERIOD + 10);
		chk(lfn[0], 1'b1);
		vco = 16'(PERIOD + 30);
		wait_lf(1'b0, PERIOD + 10);
		chk(ctl[0].force_nominal, 1'b1);
		vco = 16'(PERIOD);
		wait_lf(1'b1, 2 * PERIOD + 40);
		chk(ctl[0].force_nominal, 1'b0);
		loop_en = 4'h1;
		amp = 10'h000;
		cyc(8);
		chk(tx_out, 4'hF);
		chk(ctl[0].cdr_input_is_loop, 1'b1);
		chk(ctl[0].amp_monitor_on, 1'b0);
		cyc(60);
		chk(lfn[0], 1'b1);
		chk(lfn[1], 1'b0);
		amp = 10'h12C;
		loop_en = 4'h0;
		latch_open = 1'b1;
		bus = 8'h54;
		cyc(8);
		chk(lfn[0], 1'b0);
		chk(lfn[3:1], 3'h7);
		chk(ctl[0].powered, 1'b0);
		bus = 8'h55;
		cyc(8);
		chk(rx_en, 4'hF);
		end_sim();
	end
endmodule : rlfm_top_tb
bind rlfm_top rlfm_top_assertions #(.N(N), .PERIOD(PERIOD)) i_rlfm_chk (
	.clock                      (clock),
	.resetn                     (resetn),
	.tx_half_rate_select        (tx_half_rate_select),
	.amplitude_threshold_select (amplitude_threshold_select),
	.loopback_enable            (loopback_enable),
	.rx_enable_latch_open       (rx_enable_latch_open),
	.channel_control_bus        (channel_control_bus),
	.chan_in                    (chan_in),
	.rate_setup                 (rate_setup),
	.char_clock_tick            (char_clock_tick),
	.tx_serial_out              (tx_serial_out),
	.chan_ctl                   (chan_ctl),
	.rx_channel_enabled         (rx_channel_enabled),
	.link_fault_n               (link_fault_n)
);

// file: src/rlfm_chan.sv
// One receive channel: transition checker and range control.
// Assumes bit samples arrive one per clock and vco_count per window.
`timescale 1ns/1ns
module rlfm_chan
	import rlfm_pkg::*;
#(
	parameter int PERIOD = RANGE_PERIOD
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        enabled,
	input  wire logic        bit_in,
	input  wire logic [15:0] vco_count,
	input  wire logic [15:0] vco_nominal,
	input  wire logic        window_end,
	output logic             trans_ok,
	output logic             range_ok,
	output logic             forcing
);
	localparam logic [15:0] TOL =
		16'(RANGE_PERIOD * RANGE_PPM / 1000000);

	typedef struct packed {
		logic        prev_bit;
		logic [6:0]  quiet;
		logic        fault;
		logic [3:0]  bit_pos;
		logic        char_tr;
		logic [1:0]  good;
		logic        force_on;
		logic [4:0]  force_cnt;
		logic        in_range;
	} rlfm_chan_s;

	rlfm_chan_s st_reg;
	rlfm_chan_s st_next;
	logic       tr;
	logic [15:0] diff;

	always_comb begin
		st_next = st_reg;
		tr      = bit_in ^ st_reg.prev_bit;
		diff    = (vco_count > vco_nominal) ? vco_count - vco_nominal
		                                    : vco_nominal - vco_count;
		st_next.prev_bit = bit_in;
		// No transition for more than 60 bits raises the fault
		if (tr) begin
			st_next.quiet = '0;
		end else if (st_reg.quiet < 7'(TRANS_SPAN_BITS)) begin
			st_next.quiet = st_reg.quiet + 7'd1;
		end else begin
			st_next.fault = 1'b1;
			st_next.good  = '0;
		end
		// Character framing of 10 bits for the recovery count
		if (st_reg.bit_pos == 4'(CHAR_BITS - 1)) begin
			st_next.bit_pos = '0;
			st_next.char_tr = 1'b0;
			if (st_reg.char_tr || tr) begin
				if (st_reg.good == 2'(TRANS_GOOD_CHARS - 1)) begin
					st_next.fault = 1'b0;
				end else begin
					st_next.good = st_reg.good + 2'd1;
				end
			end else begin
				st_next.good = '0;
			end
		end else begin
			st_next.bit_pos = st_reg.bit_pos + 4'd1;
			st_next.char_tr = st_reg.char_tr | tr;
		end
		// Sample once per window; off range forces nominal
		if (window_end) begin
			st_next.in_range = (diff <= TOL);
			if (diff > TOL) begin
				st_next.force_on  = 1'b1;
				st_next.force_cnt = 5'(FORCE_CYCLES - 1);
			end
		end
		if (st_reg.force_on) begin
			if (st_reg.force_cnt == '0) begin
				st_next.force_on = 1'b0;
			end else begin
				st_next.force_cnt = st_reg.force_cnt - 5'd1;
			end
		end
		// Disabled channel powers down its state
		if (!enabled) begin
			st_next       = '0;
			st_next.fault = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '{fault: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign trans_ok = !st_reg.fault;
	assign range_ok = st_reg.in_range;
	assign forcing  = st_reg.force_on;

	if (PERIOD < 2 || PERIOD > 65535) begin : g_bad_period
		$error("PERIOD out of range");
	end

endmodule : rlfm_chan

// file: src/rlfm_pkg.sv
// Constants and carriers shared by the link-fault monitor files.
// Assumes one 125 MHz clock that stands for the reference timing input.
package rlfm_pkg;

	localparam int NUM_CHAN        = 4;
	localparam int CHAR_BITS       = 10;
	// Multiplier figures for full and half rate
	localparam int MULT_FULL       = 10;
	localparam int MULT_HALF       = 20;
	// Transition checker: span in bits, clear needs this many good chars
	localparam int TRANS_SPAN_BITS = 60;
	localparam int TRANS_GOOD_CHARS = 3;
	// Range control period in reference periods, and tolerance in ppm
	localparam int RANGE_PERIOD    = 16000;
	localparam int RANGE_PPM       = 1500;
	// Cycles the oscillator is held at nominal after a range fault
	localparam int FORCE_CYCLES    = 16;
	// Control bus width and reset value of the enable latch
	localparam int CTRL_BUS_W      = 8;
	localparam logic [3:0] RX_EN_RESET = 4'h0;

	// Three-level select codes
	typedef enum logic [1:0] {
		RLFM_LVL_LOW  = 2'b00,
		RLFM_LVL_MID  = 2'b01,
		RLFM_LVL_HIGH = 2'b10
	} rlfm_level_e;

	// Nominal trip levels in mV peak-to-peak
	localparam logic [9:0] AMP_LOW_MV  = 10'h08C;
	localparam logic [9:0] AMP_MID_MV  = 10'h118;
	localparam logic [9:0] AMP_HIGH_MV = 10'h1A4;
	// Signalling range bounds in MBaud
	localparam logic [11:0] BAUD_LOW_MIN  = 12'h0C3;
	localparam logic [11:0] BAUD_LOW_MAX  = 12'h190;
	localparam logic [11:0] BAUD_MID_MAX  = 12'h320;
	localparam logic [11:0] BAUD_HIGH_MAX = 12'h5DC;

	// Rate setup derived from the selects
	typedef struct packed {
		logic [4:0]  multiplier;
		logic [11:0] baud_min;
		logic [11:0] baud_max;
		logic        reserved_mode;
	} rlfm_rate_s;

	// Per-channel analog and recovery status inputs
	typedef struct packed {
		logic        line_bit;
		logic        loop_bit;
		logic [9:0]  amplitude_mv;
		logic [15:0] vco_count;
	} rlfm_chan_in_s;

	// Per-channel control toward the analog/recovery side
	typedef struct packed {
		logic cdr_input_is_loop;
		logic line_rx_select;
		logic amp_monitor_on;
		logic force_nominal;
		logic powered;
	} rlfm_chan_ctl_s;

	function automatic logic [9:0] rlfm_amp_trip(input rlfm_level_e s);
		case (s)
			RLFM_LVL_LOW:  rlfm_amp_trip = AMP_LOW_MV;
			RLFM_LVL_HIGH: rlfm_amp_trip = AMP_HIGH_MV;
			default:       rlfm_amp_trip = AMP_MID_MV;
		endcase
	endfunction : rlfm_amp_trip

endpackage : rlfm_pkg

// file: src/rlfm_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes input is asynchronous to clock.
`timescale 1ns/1ns
module rlfm_sync3
	import rlfm_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} rlfm_sync_s;

	rlfm_sync_s st_reg;
	rlfm_sync_s st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			// Only take a new level once stages two and three agree
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.out[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.out;

endmodule : rlfm_sync3

// file: src/rlfm_top.sv
// Link-fault monitor, loopback steering, rate setup and rx enable latch.
// Assumes analog amplitude and vco counts come from synchronous logic.
`timescale 1ns/1ns

module rlfm_top
	import rlfm_pkg::*;
#(
	parameter int N      = NUM_CHAN,
	parameter int PERIOD = RANGE_PERIOD
) (
	input  wire logic                  clock,
	input  wire logic                  resetn,
	input  wire logic                  tx_half_rate_select,
	input  wire rlfm_level_e           speed_range_select,
	input  wire rlfm_level_e           amplitude_threshold_select,
	input  wire logic [N-1:0]          loopback_enable,
	input  wire logic                  rx_enable_latch_open,
	input  wire logic [CTRL_BUS_W-1:0] channel_control_bus,
	input  wire logic [N-1:0]          tx_serial_data,
	input  wire rlfm_chan_in_s [N-1:0] chan_in,
	output rlfm_rate_s                 rate_setup,
	output logic                       char_clock_tick,
	output logic [N-1:0]               tx_serial_out,
	output rlfm_chan_ctl_s [N-1:0]     chan_ctl,
	output logic [N-1:0]               rx_channel_enabled,
	output logic [N-1:0]               link_fault_n
);
	typedef struct packed {
		logic [15:0]   win_cnt;
		logic          win_end;
		logic [4:0]    char_cnt;
		logic          char_tick;
		rlfm_rate_s    rate;
		logic [N-1:0]  rx_en;
		logic [N-1:0]  serial_out;
		logic [N-1:0]  lfi_n;
	} rlfm_top_s;

	rlfm_top_s      st_reg;
	rlfm_top_s      st_next;
	logic           latch_open_s;
	logic [CTRL_BUS_W-1:0] bus_s;
	logic [N-1:0]   loop_s;
	logic [N-1:0]   cdr_bit;
	logic [N-1:0]   trans_ok;
	logic [N-1:0]   range_ok;
	logic [N-1:0]   forcing;
	logic [N-1:0]   amp_ok;
	logic [9:0]     trip;
	logic [15:0]    vco_nominal;
	logic           half_s;
	logic [1:0]     speed_s;
	logic [1:0]     amp_sel_s;
	rlfm_level_e    speed_lvl;
	rlfm_level_e    amp_lvl;

	// Control pins are asynchronous, so pass them through the filter
	rlfm_sync3 #(.W(1 + CTRL_BUS_W + N)) u_sync (
		.clock  (clock),
		.resetn (resetn),
		.din    ({rx_enable_latch_open, channel_control_bus,
		          loopback_enable}),
		.dout   ({latch_open_s, bus_s, loop_s})
	);

	// Select pins are straps, but a change mid-run must not glitch the rate
	rlfm_sync3 #(.W(5)) u_sync_sel (
		.clock  (clock),
		.resetn (resetn),
		.din    ({tx_half_rate_select, speed_range_select,
		          amplitude_threshold_select}),
		.dout   ({half_s, speed_s, amp_sel_s})
	);

	assign speed_lvl = rlfm_level_e'(speed_s);
	assign amp_lvl   = rlfm_level_e'(amp_sel_s);
	assign trip      = rlfm_amp_trip(amp_lvl);
	// Expected vco count over one window is PERIOD, whatever the multiplier
	assign vco_nominal = 16'(PERIOD);

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_chan
			// Loopback picks the transmit bit for recovery
			assign cdr_bit[g] = loop_s[g] ? tx_serial_data[g]
			                              : chan_in[g].line_bit;
			assign amp_ok[g] = loop_s[g] ||
				(chan_in[g].amplitude_mv >= trip);
			assign chan_ctl[g].cdr_input_is_loop = loop_s[g];
			assign chan_ctl[g].line_rx_select    = !loop_s[g];
			assign chan_ctl[g].amp_monitor_on    =
				!loop_s[g] && st_reg.rx_en[g];
			assign chan_ctl[g].force_nominal     = forcing[g];
			assign chan_ctl[g].powered           = st_reg.rx_en[g];

			rlfm_chan #(.PERIOD(PERIOD)) u_chan (
				.clock       (clock),
				.resetn      (resetn),
				.enabled     (st_reg.rx_en[g]),
				.bit_in      (cdr_bit[g]),
				.vco_count   (chan_in[g].vco_count),
				.vco_nominal (vco_nominal),
				.window_end  (st_reg.win_end),
				.trans_ok    (trans_ok[g]),
				.range_ok    (range_ok[g]),
				.forcing     (forcing[g])
			);
		end
	endgenerate

	always_comb begin
		st_next = st_reg;
		// Rate setup from the selects
		st_next.rate.multiplier = half_s ? 5'(MULT_HALF)
		                                 : 5'(MULT_FULL);
		// Low range with half rate is reserved; flagged, not refused
		st_next.rate.reserved_mode = half_s &&
			(speed_lvl == RLFM_LVL_LOW);
		case (speed_lvl)
			RLFM_LVL_LOW: begin
				st_next.rate.baud_min = BAUD_LOW_MIN;
				st_next.rate.baud_max = BAUD_LOW_MAX;
			end
			RLFM_LVL_HIGH: begin
				st_next.rate.baud_min = BAUD_MID_MAX;
				st_next.rate.baud_max = BAUD_HIGH_MAX;
			end
			default: begin
				st_next.rate.baud_min = BAUD_LOW_MAX;
				st_next.rate.baud_max = BAUD_MID_MAX;
			end
		endcase
		// Character-rate tick for the transmit paths
		st_next.char_tick = 1'b0;
		if (st_reg.char_cnt >= st_next.rate.multiplier - 5'd1) begin
			st_next.char_cnt  = '0;
			st_next.char_tick = 1'b1;
		end else begin
			st_next.char_cnt = st_reg.char_cnt + 5'd1;
		end
		// Range control sampling window
		st_next.win_end = 1'b0;
		if (st_reg.win_cnt == 16'(PERIOD - 1)) begin
			st_next.win_cnt = '0;
			st_next.win_end = 1'b1;
		end else begin
			st_next.win_cnt = st_reg.win_cnt + 16'd1;
		end
		// Open latch passes bus; closed latch holds
		if (latch_open_s) begin
			for (int i = 0; i < N; i++) begin
				st_next.rx_en[i] = bus_s[2 * i];
			end
		end
		// Any loopback forces every output to static one
		st_next.serial_out = (|loop_s) ? '1 : tx_serial_data;
		// Link good needs all five conditions
		for (int i = 0; i < N; i++) begin
			st_next.lfi_n[i] = st_reg.rx_en[i]
				&& amp_ok[i]
				&& trans_ok[i]
				&& range_ok[i]
				&& !forcing[i];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_reg       <= '0;
			st_reg.rx_en <= N'(RX_EN_RESET);
		end else begin
			st_reg <= st_next;
		end
	end

	assign rate_setup         = st_reg.rate;
	assign char_clock_tick    = st_reg.char_tick;
	assign tx_serial_out      = st_reg.serial_out;
	assign rx_channel_enabled = st_reg.rx_en;
	assign link_fault_n       = st_reg.lfi_n;

	// Window counter is 16 bits and the bus carries two bits per channel
	if (N < 1 || 2 * N > CTRL_BUS_W ||
	    PERIOD < 2 || PERIOD > 65535) begin : g_bad_param
		$error("N or PERIOD does not fit bus or window counter");
	end

endmodule : rlfm_top
